// ===== sbtc_defs.vh
// Constants for the sixteen-bit timer/counter: register map, field positions,
// reset values, prescale codes and response codes.
// Included by the design file; holds definitions only.
`ifndef SBTC_DEFS_VH
`define SBTC_DEFS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SBTC_ADDR_W          8
`define SBTC_OFF_COUNT_LOW   8'h00
`define SBTC_OFF_COUNT_HIGH  8'h04
`define SBTC_OFF_STATUS      8'h08
`define SBTC_OFF_CONTROL     8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define SBTC_CTL_RUN         0
`define SBTC_CTL_SRC         1
`define SBTC_CTL_SYNC_N      2
`define SBTC_CTL_OSC_EN      3
`define SBTC_CTL_PS_LO       4
`define SBTC_CTL_PS_HI       5
`define SBTC_CTL_MASK        8'h3f
`define SBTC_CTL_RESET       8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define SBTC_STS_FLAG        0
`define SBTC_STS_IRQ_EN      1

// ****************************************************************
// Prescale codes and widths
// ****************************************************************
`define SBTC_PS_1            2'h0
`define SBTC_PS_2            2'h1
`define SBTC_PS_4            2'h2
`define SBTC_PS_8            2'h3
`define SBTC_PS_CNT_W        3
`define SBTC_PHASE_LAST      2'h3
`define SBTC_COUNT_MAX       16'hffff
`define SBTC_COUNT_ZERO      16'h0000

// ****************************************************************
// AXI response codes
// ****************************************************************
`define SBTC_RESP_OKAY       2'h0
`define SBTC_RESP_SLVERR     2'h2

`endif

// ===== sbtc_timer.v
// Sixteen-bit timer/counter with prescaler, synchronised or free external
// counting, crystal pin control and an AXI4-Lite register slave.
// Assumes all pin inputs are already synchronous to ref_clk (25 MHz).
//
// How it works
// - control bit 1 picks timer or counter
// - timer counts instruction clock, ignores sync bit
// - external counting uses rising edges only
// - first falling edge required after enabling counter
// - bits 5-4 select prescale 1,2,4,8
// - oscillator enable starts crystal, forces pins input
// - counter input: osc pin or external pin
// - sync bit low synchronises external input
// - synchronisation sits after the prescaler
// - synced counter halts in sleep, prescaler runs
// - free counter runs in sleep, wakes on overflow
// - free counter is no compare time base
// - count byte reads are always coherent
// - compare unit reset clears the count, except in free (unsynchronised) counter mode
// - run bit enables, clear holds count
// - rollover latches flag, gated by enable
// - count byte writes clear prescaler
`timescale 1ns/1ps
`include "sbtc_defs.vh"

module sbtc_timer (
  input  wire        ref_clk,
  input  wire        nrst,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Pins and system
  input  wire        ext_count_input,
  input  wire        osc_input_pin,
  input  wire [1:0]  port_direction,
  input  wire [1:0]  port_out,
  output wire        osc_input_pin_o,
  output wire        osc_input_pin_oe,
  output wire        osc_output_pin_o,
  output wire        osc_output_pin_oe,
  output wire        crystal_osc_run,
  input  wire        sleep_mode,
  input  wire        compare_reset,
  output reg  [15:0] count_value,
  output wire        compare_timebase_ok,
  output wire        overflow_irq,
  output wire        wake_request
);

  // ****************************************************************
  // Decode helper
  // ****************************************************************
  function [2:0] ps_last;
    input [1:0] code;
    begin
      case (code)
        `SBTC_PS_2: ps_last = 3'h1;
        `SBTC_PS_4: ps_last = 3'h3;
        `SBTC_PS_8: ps_last = 3'h7;
        default:    ps_last = 3'h0;
      endcase
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `SBTC_OFF_COUNT_LOW) || (a == `SBTC_OFF_COUNT_HIGH) ||
                  (a == `SBTC_OFF_STATUS) || (a == `SBTC_OFF_CONTROL);
    end
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [7:0]  control_reg;
  reg         flag_reg;
  reg         irq_en_reg;
  reg  [1:0]  phase_reg;
  reg  [2:0]  ps_cnt_reg;
  reg         in_prev_reg;
  reg         armed_reg;
  reg         run_prev_reg;
  reg         tgl_reg;
  reg         sync1_reg;
  reg         sync2_reg;
  reg         sync3_reg;

  reg         aw_held_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  wire run      = control_reg[`SBTC_CTL_RUN];
  wire ctr_mode = control_reg[`SBTC_CTL_SRC];
  wire sync_n   = control_reg[`SBTC_CTL_SYNC_N];
  wire osc_en   = control_reg[`SBTC_CTL_OSC_EN];
  wire [1:0] ps_sel = control_reg[`SBTC_CTL_PS_HI:`SBTC_CTL_PS_LO];

  // ****************************************************************
  // Pin direction control
  // ****************************************************************
  // Pin bit 1 is the crystal input, bit 0 the amplifier output / count input.
  // A direction bit of one means input, as on a normal port.
  assign crystal_osc_run   = osc_en;
  assign osc_input_pin_o   = port_out[1];
  assign osc_input_pin_oe  = ~osc_en & ~port_direction[1];
  assign osc_output_pin_o  = port_out[0];
  assign osc_output_pin_oe = ~osc_en & ~port_direction[0];

  // ****************************************************************
  // Count source
  // ****************************************************************
  wire ext_in   = osc_en ? osc_input_pin : ext_count_input;
  wire ext_rise = ext_in & ~in_prev_reg;
  wire ext_fall = ~ext_in & in_prev_reg;
  wire run_rise = run & ~run_prev_reg;

  // Prescaler is edge driven by the external input in counter mode, where it keeps going in sleep.
  wire ps_edge  = ctr_mode ? (run & armed_reg & ext_rise)
                           : (run & ~sleep_mode & (phase_reg == `SBTC_PHASE_LAST));
  wire ps_tick  = ps_edge & (ps_cnt_reg == ps_last(ps_sel));

  // Synchronised path: toggle crosses two flops after the prescaler.
  wire sync_evt = sync2_reg ^ sync3_reg;
  wire async_md = ctr_mode & sync_n;
  wire inc_now  = ~run ? 1'b0 :
                  ~ctr_mode ? ps_tick :
                  async_md  ? ps_tick :
                  (sync_evt & ~sleep_mode);

  // ****************************************************************
  // AXI write path
  // ****************************************************************
  wire do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_lane0  = do_write & w_strb_reg[0];
  wire wr_low    = wr_lane0 & (aw_addr_reg == `SBTC_OFF_COUNT_LOW);
  wire wr_high   = wr_lane0 & (aw_addr_reg == `SBTC_OFF_COUNT_HIGH);
  wire wr_status = wr_lane0 & (aw_addr_reg == `SBTC_OFF_STATUS);
  wire wr_ctl    = wr_lane0 & (aw_addr_reg == `SBTC_OFF_CONTROL);
  wire wr_count  = wr_low | wr_high;

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? `SBTC_RESP_OKAY : `SBTC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI read path
  // ****************************************************************
  // The count is a ref_clk register, so either byte reads coherently.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SBTC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? `SBTC_RESP_OKAY : `SBTC_RESP_SLVERR;
      case (s_axi_araddr)
        `SBTC_OFF_COUNT_LOW:  s_axi_rdata <= {24'h000000, count_value[7:0]};
        `SBTC_OFF_COUNT_HIGH: s_axi_rdata <= {24'h000000, count_value[15:8]};
        `SBTC_OFF_STATUS:     s_axi_rdata <= {30'h00000000, irq_en_reg, flag_reg};
        `SBTC_OFF_CONTROL:    s_axi_rdata <= {24'h000000, control_reg};
        default:              s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control and status registers
  // ****************************************************************
  wire overflow = inc_now & (count_value == `SBTC_COUNT_MAX) & ~wr_count;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      control_reg <= `SBTC_CTL_RESET;
      flag_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
    end else begin
      if (wr_ctl)
        control_reg <= w_data_reg[7:0] & `SBTC_CTL_MASK;
      if (wr_status)
        irq_en_reg <= w_data_reg[`SBTC_STS_IRQ_EN];
      // Write one clears; a rollover in the same cycle wins.
      if (overflow)
        flag_reg <= 1'b1;
      else if (wr_status && w_data_reg[`SBTC_STS_FLAG])
        flag_reg <= 1'b0;
    end
  end

  assign overflow_irq = flag_reg & irq_en_reg;
  assign wake_request = overflow_irq & sleep_mode & async_md;
  assign compare_timebase_ok = ~async_md;

  // ****************************************************************
  // Instruction clock, edge tracking and prescaler
  // ****************************************************************
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg    <= 2'h0;
      in_prev_reg  <= 1'b0;
      run_prev_reg <= 1'b0;
      armed_reg    <= 1'b0;
      ps_cnt_reg   <= 3'h0;
    end else begin
      // The core clock stops in sleep, so the phase counter does too.
      if (!sleep_mode)
        phase_reg <= phase_reg + 2'h1;
      in_prev_reg  <= ext_in;
      run_prev_reg <= run;
      // Disarmed while stopped or on enable; the next falling edge arms.
      if (!run || run_rise || !ctr_mode)
        armed_reg <= 1'b0;
      else if (ext_fall)
        armed_reg <= 1'b1;
      if (wr_count)
        ps_cnt_reg <= 3'h0;
      else if (ps_tick)
        ps_cnt_reg <= 3'h0;
      else if (ps_edge)
        ps_cnt_reg <= ps_cnt_reg + 3'h1;
    end
  end

  // ****************************************************************
  // Synchroniser after the prescaler
  // ****************************************************************
  // The chain is frozen in sleep, so synced-mode events are not counted.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tgl_reg   <= 1'b0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      if (ps_tick && ctr_mode && !sync_n)
        tgl_reg <= ~tgl_reg;
      if (!sleep_mode) begin
        sync1_reg <= tgl_reg;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
      end
    end
  end

  // ****************************************************************
  // Sixteen-bit count
  // ****************************************************************
  // A software write beats both an increment and a compare reset; software
  // should stop the timer first in the free-running mode.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_value <= `SBTC_COUNT_ZERO;
    end else if (wr_low) begin
      count_value[7:0] <= w_data_reg[7:0];
    end else if (wr_high) begin
      count_value[15:8] <= w_data_reg[7:0];
    end else if (compare_reset && !async_md) begin
      count_value <= `SBTC_COUNT_ZERO;
    end else if (inc_now) begin
      count_value <= count_value + 16'h0001;
    end
  end

endmodule

// ===== sbtc_timer_sva.sv
// Checker for the timer/counter: pin control, count stepping, sleep and wake.
// Sees only the top ports; bound to every sbtc_timer instance below.
`timescale 1ns/1ps
module sbtc_timer_sva (
  input wire        ref_clk,
  input wire        nrst,
  input wire        s_axi_bvalid,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  port_direction,
  input wire        osc_input_pin_oe,
  input wire        osc_output_pin_oe,
  input wire        crystal_osc_run,
  input wire        sleep_mode,
  input wire        compare_reset,
  input wire [15:0] count_value,
  input wire        compare_timebase_ok,
  input wire        overflow_irq,
  input wire        wake_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_osc_pins;
    crystal_osc_run |-> !osc_input_pin_oe && !osc_output_pin_oe;
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("crystal pins driven");
  property p_pin_dir;
    !crystal_osc_run |-> osc_output_pin_oe == !port_direction[0]
      && osc_input_pin_oe == !port_direction[1];
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable ignores direction");
  property p_cmp_clear;
    compare_reset && compare_timebase_ok |=> count_value == 16'h0000 || $rose(s_axi_bvalid);
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare reset missed");
  property p_step;
    $changed(count_value) && !$rose(s_axi_bvalid) && !$past(compare_reset)
      |-> count_value == $past(count_value) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count moved by more than one");
  property p_gap;
    $changed(count_value) && !$rose(s_axi_bvalid) && !$past(compare_reset)
      |=> !$changed(count_value) || $rose(s_axi_bvalid) || $past(compare_reset);
  endproperty
  a_gap: assert property (p_gap) else $error("increments on adjacent cycles");
  property p_sleep;
    $past(sleep_mode) && $past(compare_timebase_ok) && !$rose(s_axi_bvalid)
      && !$past(compare_reset) |-> $stable(count_value);
  endproperty
  a_sleep: assert property (p_sleep) else $error("synced count moved in sleep");
  property p_wake;
    wake_request |-> overflow_irq && sleep_mode && !compare_timebase_ok;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
endmodule

bind sbtc_timer sbtc_timer_sva u_sva (.*);

// ===== sbtc_edge_src.sv
// Model of an external count clock or crystal signal.
// Bursts are started by bench calls; the line rests high between bursts.
`timescale 1ns/1ps
module sbtc_edge_src (
  input  wire  ref_clk,
  output logic line
);
  initial line = 1'b1;
  // Two cycles low, two high: clean edges the design sees one by one
  task pulses(input int n);
    repeat (n) begin
      repeat (2) @(posedge ref_clk);
      line <= 1'b0;
      repeat (2) @(posedge ref_clk);
      line <= 1'b1;
    end
  endtask
  // Steady level, so that a rise can come with no falling edge before it
  task level(input logic v);
    @(posedge ref_clk);
    line <= v;
  endtask
endmodule

// ===== sixteen_bit_timer_counter_bench.sv
// Self-checking bench for the timer/counter over its AXI4-Lite port.
// Assumes two edge source models on the count and crystal input pins.
`timescale 1ns/1ps
module sixteen_bit_timer_counter_bench;
  logic ref_clk = 1'b0, nrst = 1'b0, sleep_mode = 1'b0, compare_reset = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_line, osc_line, osc_run, tb_ok, irq, wake;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] port_direction = 2'h0, port_out = 2'h3;
  logic in_o, in_oe, out_o, out_oe;
  logic [15:0] count_value, c, c_prev;
  int err_count = 0, n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  sbtc_edge_src src_x (.ref_clk(ref_clk), .line(ext_line));
  sbtc_edge_src src_o (.ref_clk(ref_clk), .line(osc_line));
  sbtc_timer dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_count_input(ext_line), .osc_input_pin(osc_line),
    .port_direction(port_direction), .port_out(port_out), .osc_input_pin_o(in_o),
    .osc_input_pin_oe(in_oe), .osc_output_pin_o(out_o), .osc_output_pin_oe(out_oe),
    .crystal_osc_run(osc_run),
    .sleep_mode(sleep_mode), .compare_reset(compare_reset), .count_value(count_value),
    .compare_timebase_ok(tb_ok), .overflow_irq(irq), .wake_request(wake));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task wr(input [7:0] a, input [31:0] v);
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata; resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rdc;
    rd(8'h00); c[7:0] = d[7:0];
    rd(8'h04); c[15:8] = d[7:0];
  endtask
  task cmp(input [31:0] got, input [31:0] lo, input [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task clr_count;
    wr(8'h00, 32'h0); wr(8'h04, 32'h0);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    rd(8'h10); cmp(d, 0, 0);
    wr(8'h10, 32'hff); rd(8'h10); cmp(d, 32'h3f, 32'h3f);
    wr(8'h10, 32'h0); rd(8'h0c); cmp(resp, 2, 2); cmp(d, 0, 0);
    // Lane 0 strobe off: write is answered but leaves the register alone
    s_axi_wstrb <= 4'h0; wr(8'h10, 32'h3f); cmp(resp, 0, 0);
    s_axi_wstrb <= 4'h1; rd(8'h10); cmp(d, 0, 0);
  endtask
  task t_timer;
    for (int k = 0; k < 4; k++) begin
      clr_count;
      wr(8'h10, {26'h0, k[1:0], 4'h5}); // Sync bit set must not matter in timer mode
      repeat (256) @(posedge ref_clk);
      wr(8'h10, 32'h0); rdc;
      cmp(c, (64 >> k) - 2, (64 >> k) + 1);
      repeat (8) @(posedge ref_clk);
      c_prev = c; rdc; cmp(c, c_prev, c_prev);
    end
  endtask
  task t_cmp;
    wr(8'h10, 32'h1);
    repeat (100) @(posedge ref_clk);
    compare_reset <= 1'b1; @(posedge ref_clk); compare_reset <= 1'b0;
    wr(8'h10, 32'h0); rdc; cmp(c, 0, 3);
    rd(8'h08); cmp(d, 0, 0);
  endtask
  task t_async;
    wr(8'h00, 32'hfe); wr(8'h04, 32'hff); wr(8'h08, 32'h2);
    sleep_mode <= 1'b1; wr(8'h10, 32'h7);
    src_x.pulses(3); repeat (2) @(posedge ref_clk);
    cmp(wake, 1, 1); cmp(irq, 1, 1); cmp(tb_ok, 0, 0);
    sleep_mode <= 1'b0; wr(8'h10, 32'h0); rdc;
    cmp(c, 16'h0001, 16'h0001);
    rd(8'h08); cmp(d, 3, 3); wr(8'h08, 32'h3); rd(8'h08); cmp(d, 2, 2);
    wr(8'h08, 32'h0);
  endtask
  task t_sync;
    clr_count; sleep_mode <= 1'b1; wr(8'h10, 32'h3);
    src_x.pulses(4); repeat (6) @(posedge ref_clk);
    rdc; cmp(c, 0, 0); cmp(tb_ok, 1, 1);
    sleep_mode <= 1'b0; src_x.pulses(2); repeat (6) @(posedge ref_clk);
    wr(8'h10, 32'h0); rdc; cmp(c, 2, 3);
  endtask
  task t_osc;
    clr_count; wr(8'h10, 32'hb);
    cmp(osc_run, 1, 1); cmp(in_oe, 0, 0); cmp(out_oe, 0, 0);
    repeat (4) @(posedge ref_clk); // Crystal start-up allowance
    src_x.pulses(3); src_o.pulses(2); repeat (6) @(posedge ref_clk);
    wr(8'h10, 32'h0); rdc; cmp(c, 2, 2);
  endtask
  task t_edges;
    // Line low at enable: its first rise has no falling edge before it
    clr_count; src_x.level(1'b0); wr(8'h10, 32'h7);
    src_x.level(1'b1); repeat (4) @(posedge ref_clk);
    rdc; cmp(c, 0, 0);
    src_x.pulses(1); repeat (2) @(posedge ref_clk);
    rdc; cmp(c, 1, 1); cmp(count_value, 1, 1);
    // 1:8 counter: five edges, stop, count write, seven edges must not tick
    wr(8'h10, 32'h0); clr_count; wr(8'h10, 32'h37);
    src_x.pulses(5); wr(8'h10, 32'h36); wr(8'h00, 32'h0); wr(8'h10, 32'h37);
    src_x.pulses(7); repeat (2) @(posedge ref_clk);
    rdc; cmp(c, 0, 0);
    src_x.pulses(1); repeat (2) @(posedge ref_clk);
    rdc; cmp(c, 1, 1);
    wr(8'h10, 32'h0);
  endtask
  task t_pins;
    port_direction <= 2'h2; port_out <= 2'h2;
    @(posedge ref_clk);
    cmp({in_oe, out_oe, in_o, out_o}, 4'h6, 4'h6);
    port_direction <= 2'h1; port_out <= 2'h1;
    @(posedge ref_clk);
    cmp({in_oe, out_oe, in_o, out_o}, 4'h9, 4'h9);
    wr(8'h10, 32'h8); cmp({in_oe, out_oe, osc_run}, 1, 1);
    wr(8'h10, 32'h0); cmp({in_oe, out_oe, osc_run}, 4, 4);
  endtask
  task summarize;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    err_count++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs; t_timer; t_cmp; t_async; t_sync; t_osc; t_edges; t_pins;
    summarize;
  end
endmodule
